//--- hw/eep_pkg.sv
// Purpose: shared constants and types for the nonvolatile array controller
// Assumes: byte addresses on a 16-bit internal bus, big-endian word order
// Notes:   register block at its reset base, array at its reset window
package eep_pkg;
    localparam logic [15:0] REG_BASE     = 16'h00F0;
    localparam logic [15:0] MCR_ADDR     = 16'h00F0;
    localparam logic [15:0] PROT_ADDR    = 16'h00F1;
    localparam logic [15:0] TEST_ADDR    = 16'h00F2;
    localparam logic [15:0] PROG_ADDR    = 16'h00F3;
    localparam logic [15:0] ARRAY_FIRST  = 16'h1000;
    localparam logic [15:0] ARRAY_LAST   = 16'h1FFF;
    localparam int          ARRAY_BYTES  = 4096;
    localparam int          ARRAY_AW     = 12;
    localparam int          ROW_LSB      = 5;
    localparam logic [7:0]  ERASED_BYTE  = 8'hFF;
    localparam logic [7:0]  ZERO_BYTE    = 8'h00;
    // block protect ranges, array-relative first offsets
    localparam logic [11:0] BLK5_FIRST   = 12'h800;
    localparam logic [11:0] BLK4_FIRST   = 12'hC00;
    localparam logic [11:0] BLK3_FIRST   = 12'hE00;
    localparam logic [11:0] BLK2_FIRST   = 12'hF00;
    localparam logic [11:0] BLK1_FIRST   = 12'hF80;
    localparam logic [11:0] BLK0_FIRST   = 12'hFC0;
    localparam logic [6:0]  PROT_RESET   = 7'h7F;

    typedef struct packed {
        logic wait_clock_stop;
        logic protect_lock;
        logic pump_clock_select;
    } eep_mcr_s;
    localparam eep_mcr_s MCR_RESET = '{wait_clock_stop: 1'b1, protect_lock: 1'b0,
                                      pump_clock_select: 1'b0};

    typedef struct packed {
        logic odd_row_bulk;
        logic even_row_bulk;
        logic voltage_margin_test;
        logic pump_disable;
        logic pump_ramp_disable;
        logic pump_voltage_monitor;
    } eep_test_s;

    typedef struct packed {
        logic bulk_erase_protect;
        logic byte_sel;
        logic row_sel;
        logic erase;
        logic latch_control;
        logic voltage_enable;
    } eep_prog_s;
    localparam eep_prog_s PROG_RESET = '{bulk_erase_protect: 1'b1, byte_sel: 1'b0,
                                        row_sel: 1'b0, erase: 1'b0,
                                        latch_control: 1'b0, voltage_enable: 1'b0};
endpackage : eep_pkg

//--- hw/eep_ctrl.sv
// Purpose: program/erase control, protection and read path of a 4 KiB array
// Assumes: one clock, plain register port, inputs synchronous to core_clk
// Notes:   program/erase takes effect when voltage is removed after a pulse
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/10ps
// Operation
// - byte and aligned word reads answer in one cycle, misaligned words in two.
// - misaligned word write for program or erase latches only its lower byte.
// - erase one byte, an aligned word, a 32-byte row or the whole array.
// - locations are erased before programming; erased bytes read all ones.
// - control registers sit at the base, the array in its 4 KiB window.
// - access enable gates array reads only, not array writes, registers or programming.
// - stop removes pump voltage and RC clock, keeps enable bit, restores after.
// - wait clock stop bit set gates the module clock during wait mode.
// - protect lock blocks protect writes; once in normal, freely in special modes.
// - pump clock select picks system clock at 0, RC oscillator at 1.
// - block protect writable only while voltage enable and lock are both 0.
// - seven protect bits guard halving ranges from lowest 2 KiB to top 64 bytes.
// - test register writable in special modes only, forced to 0 in normal.
// - odd-row and even-row bits bulk program or erase all odd or even rows.
// - other test bits select margin test, pump off, ramp off, pump to pin.
// - bulk protect blocks bulk and row erase; same write interlock as protect bits.
// - with erase set, byte and row choose bulk, row or byte erase.
// - byte erase hits only the latched location, byte or word by write width.
// - while latch control is set the array cannot be read at all.
// - voltage enable sets only if latch already set; joint write sets latch only.
// - voltage enable freezes mode bits, latches, and ignores array writes.
module eep_ctrl (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic [15:0] addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    input  wire logic        word,
    input  wire logic        normal_mode_flag,
    input  wire logic        array_access_enable,
    input  wire logic        wait_mode,
    input  wire logic        stop_mode,
    output logic      [15:0] rdata,
    output logic             rd_valid,
    output logic             hv_on,
    output logic             rc_run,
    output logic             mod_clk_en,
    output logic             pump_pin,
    output logic             margin_on,
    output logic             ramp_off
);
    logic [7:0]         mem [eep_pkg::ARRAY_BYTES];
    eep_pkg::eep_mcr_s  mcr;
    eep_pkg::eep_mcr_s  next_mcr;
    logic               lock_written;
    logic               next_lock_written;
    logic [6:0]         prot;
    logic [6:0]         next_prot;
    eep_pkg::eep_test_s test;
    eep_pkg::eep_test_s next_test;
    eep_pkg::eep_prog_s prog;
    eep_pkg::eep_prog_s next_prog;
    logic [11:0]        lat_addr;
    logic [11:0]        next_lat_addr;
    logic [15:0]        lat_data;
    logic [15:0]        next_lat_data;
    logic               lat_word;
    logic               next_lat_word;
    logic               lat_valid;
    logic               next_lat_valid;
    logic               hv_seen;
    logic               next_hv_seen;
    logic               mis_pend;
    logic               next_mis_pend;
    logic [15:0]        mis_data;
    logic [15:0]        next_mis_data;
    logic [15:0]        next_rdata;
    logic               next_rd_valid;
    logic               next_hv_on;
    logic               next_rc_run;
    logic               next_mod_clk_en;
    logic               fire;
    logic               clk_on;
    logic               in_array;

    function automatic logic is_array(input logic [15:0] a);
        return (a >= eep_pkg::ARRAY_FIRST) && (a <= eep_pkg::ARRAY_LAST);
    endfunction : is_array

    // protect bit covering an array-relative offset
    function automatic logic is_prot(input logic [11:0] o, input logic [6:0] bp);
        if (o >= eep_pkg::BLK0_FIRST)
            return bp[0];
        else if (o >= eep_pkg::BLK1_FIRST)
            return bp[1];
        else if (o >= eep_pkg::BLK2_FIRST)
            return bp[2];
        else if (o >= eep_pkg::BLK3_FIRST)
            return bp[3];
        else if (o >= eep_pkg::BLK4_FIRST)
            return bp[4];
        else if (o >= eep_pkg::BLK5_FIRST)
            return bp[5];
        else
            return bp[6];
    endfunction : is_prot

    // one byte as software sees it; unmapped and blocked bytes read zero
    function automatic logic [7:0] rd_byte(input logic [15:0] a);
        unique case (a)
            eep_pkg::MCR_ADDR:  return {5'h00, mcr};
            eep_pkg::PROT_ADDR: return {1'b1, prot};
            eep_pkg::TEST_ADDR: return {test[5:1], 1'b0, test[0], 1'b0};
            eep_pkg::PROG_ADDR: return {prog[5], 2'b00, prog[4:0]};
            default:
            begin
                if (is_array(a) && array_access_enable && !prog.latch_control)
                    return mem[a[11:0]];
                else
                    return eep_pkg::ZERO_BYTE;
            end
        endcase
    endfunction : rd_byte

    assign clk_on   = !(wait_mode && mcr.wait_clock_stop);
    assign in_array = is_array(addr);
    // operation completes when voltage is removed after having been applied
    assign fire     = prog.voltage_enable && !next_prog.voltage_enable && hv_seen && lat_valid;

    always_comb
    begin
        next_mcr          = mcr;
        next_lock_written = lock_written;
        next_prot         = prot;
        next_test         = test;
        next_prog         = prog;
        if (clk_on && wr && (addr == eep_pkg::MCR_ADDR))
        begin
            next_mcr.wait_clock_stop   = wdata[2];
            next_mcr.pump_clock_select = wdata[0];
            if (!normal_mode_flag || !lock_written)
            begin
                next_mcr.protect_lock = wdata[1];
                next_lock_written     = normal_mode_flag;
            end
        end
        if (clk_on && wr && (addr == eep_pkg::PROT_ADDR)
            && !prog.voltage_enable && !mcr.protect_lock)
            next_prot = wdata[6:0];
        if (clk_on && wr && (addr == eep_pkg::TEST_ADDR) && !normal_mode_flag)
            next_test = {wdata[7:3], wdata[1]};
        if (normal_mode_flag)
            next_test = '0;
        if (clk_on && wr && (addr == eep_pkg::PROG_ADDR))
        begin
            if (!prog.voltage_enable)
            begin
                if (!mcr.protect_lock)
                    next_prog.bulk_erase_protect = wdata[7];
                next_prog.byte_sel      = wdata[4];
                next_prog.row_sel       = wdata[3];
                next_prog.erase         = wdata[2];
                next_prog.latch_control = wdata[1];
                // only a latch already set lets voltage come on
                next_prog.voltage_enable = wdata[0] && prog.latch_control;
            end
            else
                next_prog.voltage_enable = wdata[0];
        end
    end

    always_comb
    begin
        next_lat_addr  = lat_addr;
        next_lat_data  = lat_data;
        next_lat_word  = lat_word;
        next_lat_valid = lat_valid && prog.latch_control;
        next_hv_seen   = (hv_seen || hv_on) && prog.voltage_enable;
        // array write while latching captures the target, ignored under voltage
        if (clk_on && wr && in_array && prog.latch_control && !prog.voltage_enable)
        begin
            next_lat_addr  = addr[11:0];
            next_lat_valid = 1'b1;
            next_lat_word  = word && !addr[0];
            if (word)
                next_lat_data = wdata;
            else
                next_lat_data = {wdata[7:0], wdata[7:0]};
        end
        next_hv_on      = prog.voltage_enable && !stop_mode && !test.pump_disable;
        next_rc_run     = prog.voltage_enable && !stop_mode && mcr.pump_clock_select;
        next_mod_clk_en = clk_on;
    end

    // read path: a misaligned word spends an extra cycle on its second byte
    always_comb
    begin
        next_rdata    = rdata;
        next_rd_valid = 1'b0;
        next_mis_pend = 1'b0;
        next_mis_data = mis_data;
        if (mis_pend)
        begin
            next_rdata    = mis_data;
            next_rd_valid = 1'b1;
        end
        else if (clk_on && rd)
        begin
            if (word && addr[0])
            begin
                next_mis_pend = 1'b1;
                next_mis_data = {rd_byte(addr), rd_byte(addr + 16'h0001)};
            end
            else if (word)
            begin
                next_rdata    = {rd_byte(addr), rd_byte(addr | 16'h0001)};
                next_rd_valid = 1'b1;
            end
            else
            begin
                next_rdata    = {eep_pkg::ZERO_BYTE, rd_byte(addr)};
                next_rd_valid = 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            mcr          <= eep_pkg::MCR_RESET;
            lock_written <= 1'b0;
            prot         <= eep_pkg::PROT_RESET;
            test         <= '0;
            prog         <= eep_pkg::PROG_RESET;
            lat_addr     <= '0;
            lat_data     <= '0;
            lat_word     <= 1'b0;
            lat_valid    <= 1'b0;
            hv_seen      <= 1'b0;
            mis_pend     <= 1'b0;
            mis_data     <= '0;
            rdata        <= '0;
            rd_valid     <= 1'b0;
            hv_on        <= 1'b0;
            rc_run       <= 1'b0;
            mod_clk_en   <= 1'b1;
            pump_pin     <= 1'b0;
            margin_on    <= 1'b0;
            ramp_off     <= 1'b0;
        end
        else
        begin
            mcr          <= next_mcr;
            lock_written <= next_lock_written;
            prot         <= next_prot;
            test         <= next_test;
            prog         <= next_prog;
            lat_addr     <= next_lat_addr;
            lat_data     <= next_lat_data;
            lat_word     <= next_lat_word;
            lat_valid    <= next_lat_valid;
            hv_seen      <= next_hv_seen;
            mis_pend     <= next_mis_pend;
            mis_data     <= next_mis_data;
            rdata        <= next_rdata;
            rd_valid     <= next_rd_valid;
            hv_on        <= next_hv_on;
            rc_run       <= next_rc_run;
            mod_clk_en   <= next_mod_clk_en;
            pump_pin     <= test.pump_voltage_monitor;
            margin_on    <= test.voltage_margin_test;
            ramp_off     <= test.pump_ramp_disable;
        end
    end

    // array cells carry no reset; erased state is all ones
    always_ff @(posedge core_clk)
    begin
        if (fire)
        begin
            for (int i = 0; i < eep_pkg::ARRAY_BYTES; i++)
            begin
                logic [11:0] o;
                logic        hit;
                logic        odd_row;
                o       = i[eep_pkg::ARRAY_AW-1:0];
                odd_row = o[eep_pkg::ROW_LSB];
                if (test.odd_row_bulk || test.even_row_bulk)
                    hit = (odd_row ? test.odd_row_bulk : test.even_row_bulk)
                          && !(prog.erase && prog.bulk_erase_protect);
                else if (!prog.erase || prog.byte_sel)
                    hit = (o == lat_addr) || (lat_word && (o == (lat_addr | 12'h001)));
                else if (prog.row_sel)
                    hit = (o[eep_pkg::ARRAY_AW-1:eep_pkg::ROW_LSB]
                           == lat_addr[eep_pkg::ARRAY_AW-1:eep_pkg::ROW_LSB])
                          && !prog.bulk_erase_protect;
                else
                    hit = !prog.bulk_erase_protect;
                if (hit && !is_prot(o, prot))
                begin
                    if (prog.erase)
                        mem[i] <= eep_pkg::ERASED_BYTE;
                    else if (o[0])
                        mem[i] <= mem[i] & lat_data[7:0];
                    else
                        mem[i] <= mem[i] & lat_data[15:8];
                end
            end
        end
    end

    pgm_needs_latch_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $rose(prog.voltage_enable) |-> $past(prog.latch_control))
        else $error("voltage enable rose without latch already set");
    test_forced_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
        $past(normal_mode_flag) |-> (test == '0))
        else $error("test bits not zero in normal mode");
    stop_drops_hv_a: assert property (@(posedge core_clk) disable iff (!nrst)
        stop_mode |=> !hv_on && !rc_run)
        else $error("pump voltage or rc clock active in stop");
    stop_keeps_bit_a: assert property (@(posedge core_clk) disable iff (!nrst)
        prog.voltage_enable && stop_mode && !wr |=> prog.voltage_enable)
        else $error("voltage enable lost in stop");
    pgm_freezes_mode_a: assert property (@(posedge core_clk) disable iff (!nrst)
        prog.voltage_enable |=> $stable(prog[5:1]) && $stable(lat_addr) && $stable(lat_data))
        else $error("mode bits or latches changed under voltage");
    prot_write_lock_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (prog.voltage_enable || mcr.protect_lock) |=> $stable(prot))
        else $error("block protect changed while locked");
    wait_gates_clk_a: assert property (@(posedge core_clk) disable iff (!nrst)
        wait_mode && mcr.wait_clock_stop |=> !mod_clk_en)
        else $error("module clock not gated in wait");
    aligned_read_lat_a: assert property (@(posedge core_clk) disable iff (!nrst)
        clk_on && rd && !mis_pend && !(word && addr[0]) |=> rd_valid)
        else $error("aligned read not answered in one cycle");
    mis_read_lat_a: assert property (@(posedge core_clk) disable iff (!nrst)
        clk_on && rd && !mis_pend && word && addr[0] |=> !rd_valid ##1 rd_valid)
        else $error("misaligned read not answered in two cycles");
    latch_blocks_rd_a: assert property (@(posedge core_clk) disable iff (!nrst)
        clk_on && rd && !mis_pend && !word && in_array && prog.latch_control
        |=> rdata == 16'h0000)
        else $error("array readable while latch set");
    pump_off_hv_a: assert property (@(posedge core_clk) disable iff (!nrst)
        test.pump_disable |=> !hv_on)
        else $error("pump voltage on while pump disabled");
    monitor_pin_a: assert property (@(posedge core_clk) disable iff (!nrst)
        test.pump_voltage_monitor |=> pump_pin)
        else $error("pump voltage not routed to pin");
endmodule : eep_ctrl

//--- sim/eep_ctrl_tb_top.sv
// Purpose: self-checking bench for the array program/erase controller
// Assumes: register port strobes are one cycle, read data one cycle later, misaligned words two
// Notes:   array bytes modelled in the bench; compared after program and erase
`timescale 1ns/10ps
module eep_ctrl_tb_top;
    logic        core_clk;
    logic        nrst;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic        word;
    logic        normal_mode_flag;
    logic        array_access_enable;
    logic        wait_mode;
    logic        stop_mode;
    logic [15:0] rdata;
    logic        rd_valid;
    logic        hv_on;
    logic        rc_run;
    logic        mod_clk_en;
    logic        pump_pin;
    logic        margin_on;
    logic        ramp_off;
    int          fail_count;
    int          checked;
    logic [7:0]  mem [4096];
    logic [6:0]  pb;
    logic [15:0] rw;
    logic [15:0] rw2;

    eep_ctrl dut (.core_clk(core_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .word(word), .normal_mode_flag(normal_mode_flag),
        .array_access_enable(array_access_enable), .wait_mode(wait_mode),
        .stop_mode(stop_mode), .rdata(rdata), .rd_valid(rd_valid), .hv_on(hv_on),
        .rc_run(rc_run), .mod_clk_en(mod_clk_en), .pump_pin(pump_pin),
        .margin_on(margin_on), .ramp_off(ramp_off));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e)
        begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // array-relative protection lookup, halving ranges toward the top
    function automatic bit prot(input int i);
        return (i < 'h800) ? pb[6] : (i < 'hC00) ? pb[5] : (i < 'hE00) ? pb[4] :
               (i < 'hF00) ? pb[3] : (i < 'hF80) ? pb[2] : (i < 'hFC0) ? pb[1] : pb[0];
    endfunction : prot

    task automatic mset(input int i, input logic [7:0] v, input bit er);
        if (!prot(i))
            mem[i] = er ? 8'hFF : (mem[i] & v);
    endtask : mset

    task automatic wr_t(input logic [15:0] a, input logic [15:0] d, input bit w);
        @(posedge core_clk);
        addr  <= a;
        wdata <= d;
        word  <= w;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr    <= 1'b0;
    endtask : wr_t

    // misaligned word answers one cycle later than the rest
    task automatic rd_t(input string n, input logic [15:0] a, input bit w,
                        input logic [15:0] e);
        @(posedge core_clk);
        addr <= a;
        word <= w;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd   <= 1'b0;
        #1;
        if (w && a[0])
        begin
            chk({n, " early"}, 16'h0000, {15'h0000, rd_valid});
            @(posedge core_clk);
            #1;
        end
        chk({n, " valid"}, 16'h0001, {15'h0000, rd_valid});
        chk(n, e, rdata);
    endtask : rd_t

    function automatic logic [15:0] ex(input logic [15:0] a, input bit w);
        int i;
        i = a - 16'h1000;
        return w ? {mem[i], mem[i + 1]} : {8'h00, mem[i]};
    endfunction : ex

    // full software sequence; m holds bulk/byte/row/erase bits
    task automatic pe(input logic [7:0] m, input logic [15:0] a, input logic [15:0] d,
                      input bit w);
        wr_t(16'h00F3, {8'h00, m | 8'h02}, 1'b0);
        wr_t(a, d, w);
        wr_t(16'h00F3, {8'h00, m | 8'h03}, 1'b0);
        repeat (3) @(posedge core_clk);
        #1;
        chk("hv_on", 16'h0001, {15'h0000, hv_on});
        wr_t(16'h00F3, {8'h00, m | 8'h02}, 1'b0);
        wr_t(16'h00F3, {8'h00, m}, 1'b0);
    endtask : pe

    task automatic tdone(input string n);
        $display("test %s done", n);
    endtask : tdone

    task automatic do_reset;
        @(posedge core_clk);
        nrst <= 1'b0;
        repeat (4) @(posedge core_clk);
        nrst <= 1'b1;
        pb = 7'h7F;
    endtask : do_reset

    initial
    begin
        #2000000;
        fail_count++;
        report_and_stop();
    end

    initial
    begin
        nrst = 1'b0; addr = 16'h0000; wdata = 16'h0000; wr = 1'b0; rd = 1'b0;
        word = 1'b0; normal_mode_flag = 1'b1; array_access_enable = 1'b1;
        wait_mode = 1'b0; stop_mode = 1'b0; fail_count = 0; checked = 0;
        void'($urandom(32'hB678));
        do_reset();
        rd_t("mcr", 16'h00F0, 1'b0, 16'h0004);
        rd_t("prot", 16'h00F1, 1'b0, 16'h00FF);
        rd_t("test", 16'h00F2, 1'b0, 16'h0000);
        rd_t("prog", 16'h00F3, 1'b0, 16'h0080);
        rd_t("unmapped", 16'h00F4, 1'b0, 16'h0000);
        wr_t(16'h00F1, 16'h0000, 1'b0); pb = 7'h00;
        wr_t(16'h00F3, 16'h0000, 1'b0);
        rd_t("prot clr", 16'h00F1, 1'b0, 16'h0080);
        rd_t("prog clr", 16'h00F3, 1'b0, 16'h0000);
        tdone("reset");
        pe(8'h04, 16'h1000, 16'h0000, 1'b0);
        for (int i = 0; i < 4096; i++) mset(i, 8'h00, 1'b1);
        rd_t("bulk lo", 16'h1000, 1'b0, 16'h00FF);
        rd_t("bulk hi", 16'h1FFF, 1'b0, 16'h00FF);
        rd_t("bulk w", 16'h1800, 1'b1, 16'hFFFF);
        tdone("bulk");
        rw = $urandom; rw2 = $urandom;
        pe(8'h00, 16'h1010, rw, 1'b0); mset('h10, rw[7:0], 1'b0);
        pe(8'h00, 16'h1020, rw2, 1'b1); mset('h20, rw2[15:8], 1'b0); mset('h21, rw2[7:0], 1'b0);
        pe(8'h00, 16'h1031, rw, 1'b1); mset('h31, rw[7:0], 1'b0);
        rd_t("pgm byte", 16'h1010, 1'b0, ex(16'h1010, 1'b0));
        rd_t("pgm word", 16'h1020, 1'b1, ex(16'h1020, 1'b1));
        rd_t("pgm mis", 16'h1031, 1'b1, ex(16'h1031, 1'b1));
        rd_t("b2b", 16'h1021, 1'b0, ex(16'h1021, 1'b0));
        tdone("program");
        pe(8'h14, 16'h1020, 16'h0000, 1'b1); mset('h20, 8'h00, 1'b1); mset('h21, 8'h00, 1'b1);
        rd_t("byte ers", 16'h1020, 1'b1, ex(16'h1020, 1'b1));
        pe(8'h00, 16'h1045, rw, 1'b0); mset('h45, rw[7:0], 1'b0);
        pe(8'h0C, 16'h1040, 16'h0000, 1'b0);
        for (int i = 'h40; i < 'h60; i++) mset(i, 8'h00, 1'b1);
        rd_t("row ers", 16'h1045, 1'b0, ex(16'h1045, 1'b0));
        rd_t("row keep", 16'h1031, 1'b1, ex(16'h1031, 1'b1));
        tdone("erase");
        wr_t(16'h00F0, 16'h0005, 1'b0);
        wr_t(16'h00F3, 16'h0003, 1'b0);
        rd_t("joint set", 16'h00F3, 1'b0, 16'h0002);
        rd_t("latch rd", 16'h1010, 1'b0, 16'h0000);
        wr_t(16'h00F3, 16'h0003, 1'b0);
        wr_t(16'h00F1, 16'h007F, 1'b0);
        rd_t("prot frz", 16'h00F1, 1'b0, 16'h0080);
        wr_t(16'h00F3, 16'h001D, 1'b0);
        rd_t("mode frz", 16'h00F3, 1'b0, 16'h0003);
        wr_t(16'h1010, 16'h0000, 1'b0);
        #1;
        chk("rc_run", 16'h0001, {15'h0000, rc_run});
        @(posedge core_clk); stop_mode <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1;
        chk("stop hv", 16'h0000, {15'h0000, hv_on});
        chk("stop rc", 16'h0000, {15'h0000, rc_run});
        @(posedge core_clk); stop_mode <= 1'b0;
        rd_t("stop keep", 16'h00F3, 1'b0, 16'h0003);
        chk("resume hv", 16'h0001, {15'h0000, hv_on});
        wr_t(16'h00F3, 16'h0002, 1'b0);
        wr_t(16'h00F3, 16'h0000, 1'b0);
        rd_t("no write", 16'h1010, 1'b0, ex(16'h1010, 1'b0));
        wr_t(16'h00F0, 16'h0004, 1'b0);
        tdone("interlock");
        wr_t(16'h00F1, 16'h0001, 1'b0); pb = 7'h01;
        pe(8'h00, 16'h1FC0, 16'h0000, 1'b0); mset('hFC0, 8'h00, 1'b0);
        pe(8'h00, 16'h1FBF, rw2, 1'b0); mset('hFBF, rw2[7:0], 1'b0);
        rd_t("blk prot", 16'h1FC0, 1'b0, ex(16'h1FC0, 1'b0));
        rd_t("blk open", 16'h1FBF, 1'b0, ex(16'h1FBF, 1'b0));
        pe(8'h84, 16'h1000, 16'h0000, 1'b0);
        rd_t("bulk prot", 16'h1010, 1'b0, ex(16'h1010, 1'b0));
        wr_t(16'h00F3, 16'h0000, 1'b0);
        tdone("protect");
        @(posedge core_clk); wait_mode <= 1'b1;
        repeat (2) @(posedge core_clk);
        #1;
        chk("wait stop", 16'h0000, {15'h0000, mod_clk_en});
        @(posedge core_clk); wait_mode <= 1'b0;
        wr_t(16'h00F0, 16'h0000, 1'b0);
        @(posedge core_clk); wait_mode <= 1'b1;
        rd_t("wait run", 16'h00F0, 1'b0, 16'h0000);
        chk("wait clk", 16'h0001, {15'h0000, mod_clk_en});
        @(posedge core_clk); wait_mode <= 1'b0; array_access_enable <= 1'b0;
        rd_t("access off", 16'h1010, 1'b0, 16'h0000);
        rd_t("reg on", 16'h00F1, 1'b0, 16'h0081);
        @(posedge core_clk); array_access_enable <= 1'b1;
        tdone("modes");
        wr_t(16'h00F2, 16'h00FF, 1'b0);
        rd_t("test norm", 16'h00F2, 1'b0, 16'h0000);
        @(posedge core_clk); normal_mode_flag <= 1'b0;
        wr_t(16'h00F2, 16'h0020, 1'b0);
        rd_t("test spec", 16'h00F2, 1'b0, 16'h0020);
        chk("margin", 16'h0001, {15'h0000, margin_on});
        wr_t(16'h00F2, 16'h008A, 1'b0);
        pe(8'h04, 16'h1000, 16'h0000, 1'b0);
        for (int i = 0; i < 4096; i++) if (i[5]) mset(i, 8'h00, 1'b1);
        rd_t("odd row", 16'h1FBF, 1'b0, ex(16'h1FBF, 1'b0));
        rd_t("even row", 16'h1010, 1'b0, ex(16'h1010, 1'b0));
        chk("pump_pin", 16'h0001, {15'h0000, pump_pin});
        chk("ramp_off", 16'h0001, {15'h0000, ramp_off});
        wr_t(16'h00F2, 16'h0010, 1'b0);
        wr_t(16'h00F3, 16'h0002, 1'b0);
        wr_t(16'h00F3, 16'h0003, 1'b0);
        repeat (3) @(posedge core_clk);
        #1;
        chk("pump off", 16'h0000, {15'h0000, hv_on});
        wr_t(16'h00F3, 16'h0002, 1'b0);
        wr_t(16'h00F3, 16'h0000, 1'b0);
        wr_t(16'h00F2, 16'h0000, 1'b0);
        wr_t(16'h00F0, 16'h0002, 1'b0);
        wr_t(16'h00F1, 16'h0000, 1'b0);
        rd_t("lock spec", 16'h00F1, 1'b0, 16'h0081);
        wr_t(16'h00F0, 16'h0000, 1'b0);
        rd_t("unlock", 16'h00F0, 1'b0, 16'h0000);
        @(posedge core_clk); normal_mode_flag <= 1'b1;
        do_reset();
        wr_t(16'h00F0, 16'h0006, 1'b0);
        wr_t(16'h00F0, 16'h0004, 1'b0);
        rd_t("lock once", 16'h00F0, 1'b0, 16'h0006);
        wr_t(16'h00F1, 16'h0000, 1'b0);
        rd_t("lock prot", 16'h00F1, 1'b0, 16'h00FF);
        tdone("lock");
        report_and_stop();
    end
endmodule : eep_ctrl_tb_top
